// ===== common/sds_pkg.sv
package sds_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Bus and register widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W  = 16;
   localparam int IRQ_W  = 2;
   localparam int CNT_W  = 8;

   ////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_PORT_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_SD_CTRL   = 8'h20;
   localparam logic [ADDR_W-1:0] OFF_SD_STATUS = 8'h2C;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STAT  = 8'h34;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK  = 8'h38;

   ////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int BIT_SD_EN    = 2;
   localparam int BIT_SD_INV   = 3;
   localparam int BIT_PWR_DOWN = 11;
   localparam int BIT_FILT_DIS = 14;
   localparam int BIT_ST_CHG   = 7;
   localparam int BIT_ST_POL   = 8;
   localparam int BIT_ST_FILT  = 9;
   localparam int IRQ_FILT     = 0;
   localparam int IRQ_POL      = 1;

   ////////////////////////////////////////////////////////////////////////
   // Reset values and writable-bit masks
   localparam logic [REG_W-1:0] RST_SD_CTRL     = 16'h0004;
   localparam logic [REG_W-1:0] RST_PORT_CTRL   = 16'h0000;
   localparam logic [IRQ_W-1:0] RST_IRQ         = 2'h0;
   localparam logic [REG_W-1:0] WMASK_SD_CTRL   = 16'h400C;
   localparam logic [REG_W-1:0] WMASK_PORT_CTRL = 16'h0800;

   ////////////////////////////////////////////////////////////////////////
   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////
   // Timing: least glitch width rounds up to whole cycles
   localparam int CLK_PERIOD_NS  = 20;
   localparam int GLITCH_NS      = 16;
   localparam int GLITCH_CYC_RAW = (GLITCH_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
   localparam int GLITCH_CYC     = (GLITCH_CYC_RAW < 1) ? 1 : GLITCH_CYC_RAW;
   localparam int FILTER_CYC_DEF = 16;

endpackage : sds_pkg

// ===== common/sds_filt_if.sv
`timescale 1ns/1ps
`default_nettype none

// Signals between the register core and the deglitch filter
interface sds_filt_if;
   logic sd_in;     // Synchronised, polarity-adjusted detect
   logic en;        // Detect enable, low forces output high
   logic filt_dis;  // Main filter bypass, glitch stage stays
   logic hold;      // Port powered down, filter frozen while detect enabled
   logic filt_out;  // Filtered detect

   modport ctl (output sd_in, output en, output filt_dis, output hold,
                input filt_out);
   modport flt (input sd_in, input en, input filt_dis, input hold,
                output filt_out);
endinterface : sds_filt_if

`default_nettype wire

// ===== logic/sds_sync2.sv
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for the detect pin
module sds_sync2
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic d,
   output var  logic q
);
   logic meta;
   logic next_meta;
   logic next_q;

   // First flop feeds only the second
   always_comb
   begin
      next_meta = d;
      next_q    = meta;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta <= 1'b0;
         q    <= 1'b0;
      end
      else
      begin
         meta <= next_meta;
         q    <= next_q;
      end
   end
endmodule : sds_sync2

`default_nettype wire

// ===== logic/sds_sd_filter.sv
`timescale 1ns/1ps
`default_nettype none

// Deglitch filter: output follows input after it differs long enough
module sds_sd_filter
   import sds_pkg::*;
#(
   parameter int FILTER_CYC = FILTER_CYC_DEF
)
(
   input  wire logic aclk,
   input  wire logic aresetn,
   sds_filt_if.flt   fi
);
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic [CNT_W-1:0] need;
   logic             out;
   logic             next_out;

   // Count consecutive differing samples; glitch stage when bypassed
   always_comb
   begin
      need     = fi.filt_dis ? CNT_W'(GLITCH_CYC) : CNT_W'(FILTER_CYC);
      next_cnt = cnt;
      next_out = out;
      if (!fi.en)
      begin
         next_out = 1'b1;
         next_cnt = '0;
      end
      else if (fi.hold)
      begin
         next_cnt = cnt;                   // Frozen while powered down
      end
      else if (fi.sd_in == out)
      begin
         next_cnt = '0;
      end
      else if (cnt >= need)
      begin
         next_out = fi.sd_in;
         next_cnt = '0;
      end
      else
      begin
         next_cnt = cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt <= '0;
         out <= 1'b0;
      end
      else
      begin
         cnt <= next_cnt;
         out <= next_out;
      end
   end

   assign fi.filt_out = out;
endmodule : sds_sd_filter

`default_nettype wire

// ===== logic/sds_top.sv
// Overview of operation
// - Status bit 9 always shows filtered detect
// - Filtered status keeps updating with filter disabled
// - Glitches under 16 ns always removed
// - Filtered detect drives PCS synchronisation qualifier
// - Detect disabled forces filtered output high
// - Status bit 8 shows pin, inverted if selected
// - Bit 8 keeps updating while powered down
// - Bit 7 sticky on bit 9 change, read clears
// - Reserved status bits read zero, software writes zero
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module sds_top
#(
   parameter int FILTER_CYC = sds_pkg::FILTER_CYC_DEF
)
(
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   // Write address channel
   input  wire logic [sds_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output var  logic                       s_axi_awready,
   // Write data channel
   input  wire logic [sds_pkg::DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output var  logic                       s_axi_wready,
   // Write response channel
   output var  logic [1:0]                 s_axi_bresp,
   output var  logic                       s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   // Read address channel
   input  wire logic [sds_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output var  logic                       s_axi_arready,
   // Read data channel
   output var  logic [sds_pkg::DATA_W-1:0] s_axi_rdata,
   output var  logic [1:0]                 s_axi_rresp,
   output var  logic                       s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   // Link side
   input  wire logic                       signal_detect_pin,
   output var  logic                       sd_pcs_qual,
   output var  logic                       irq
);
   import sds_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic              aw_held;
   logic              next_aw_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [ADDR_W-1:0] next_aw_addr;
   logic              w_held;
   logic              next_w_held;
   logic [DATA_W-1:0] w_data;
   logic [DATA_W-1:0] next_w_data;
   logic [3:0]        w_strb;
   logic [3:0]        next_w_strb;
   logic              bvalid;
   logic              next_bvalid;
   logic [1:0]        bresp;
   logic [1:0]        next_bresp;
   logic              do_write;
   logic [REG_W-1:0]  wmask;
   logic [REG_W-1:0]  wval;

   logic              rvalid;
   logic              next_rvalid;
   logic [DATA_W-1:0] rdata;
   logic [DATA_W-1:0] next_rdata;
   logic [1:0]        rresp;
   logic [1:0]        next_rresp;
   logic              do_read;
   logic              rd_status;

   logic [REG_W-1:0]  sd_ctrl;
   logic [REG_W-1:0]  next_sd_ctrl;
   logic [REG_W-1:0]  port_ctrl;
   logic [REG_W-1:0]  next_port_ctrl;
   logic [IRQ_W-1:0]  irq_stat;
   logic [IRQ_W-1:0]  next_irq_stat;
   logic [IRQ_W-1:0]  irq_mask;
   logic [IRQ_W-1:0]  next_irq_mask;
   logic              next_irq;

   logic              chg_flag;
   logic              next_chg_flag;
   logic              filt_prev;
   logic              next_filt_prev;
   logic              pol_prev;
   logic              next_pol_prev;
   logic              pol_out;
   logic              next_pol_out;
   logic              filt_chg;
   logic              pol_chg;
   logic [IRQ_W-1:0]  irq_evt;

   logic              pin_sync;
   logic [REG_W-1:0]  status_word;

   sds_filt_if        fi ();

   ////////////////////////////////////////////////////////////////////////
   // Pin synchroniser and deglitch filter
   sds_sync2 i_sds_sync2
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       (signal_detect_pin),
      .q       (pin_sync)
   );

   // Filter inputs from control bits; inversion after synchronising
   assign fi.sd_in    = pin_sync ^ sd_ctrl[BIT_SD_INV];
   assign fi.en       = sd_ctrl[BIT_SD_EN];
   assign fi.filt_dis = sd_ctrl[BIT_FILT_DIS];
   assign fi.hold     = port_ctrl[BIT_PWR_DOWN];

   sds_sd_filter #(
      .FILTER_CYC (FILTER_CYC)
   ) i_sds_sd_filter
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .fi      (fi)
   );

   // Filtered detect qualifies PCS synchronisation
   assign sd_pcs_qual = fi.filt_out;

   ////////////////////////////////////////////////////////////////////////
   // Status word: reserved bits are constant zero
   always_comb
   begin
      status_word              = '0;
      status_word[BIT_ST_FILT] = fi.filt_out;
      status_word[BIT_ST_POL]  = pol_out;
      status_word[BIT_ST_CHG]  = chg_flag;
   end

   ////////////////////////////////////////////////////////////////////////
   // Change detection and sticky change flag
   assign filt_chg  = fi.filt_out != filt_prev;
   assign pol_chg   = pol_out != pol_prev;
   assign rd_status = do_read
                      && (s_axi_araddr[ADDR_W-1:2] == OFF_SD_STATUS[ADDR_W-1:2]);

   always_comb
   begin
      next_filt_prev = fi.filt_out;
      next_pol_prev  = pol_out;
      // Polarity view follows pin even when powered down
      next_pol_out   = fi.sd_in;
      next_chg_flag  = chg_flag;
      if (rd_status)
      begin
         next_chg_flag = 1'b0;
      end
      if (filt_chg)
      begin
         next_chg_flag = 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         filt_prev <= 1'b0;
         pol_prev  <= 1'b0;
         pol_out   <= 1'b0;
         chg_flag  <= 1'b0;
      end
      else
      begin
         filt_prev <= next_filt_prev;
         pol_prev  <= next_pol_prev;
         pol_out   <= next_pol_out;
         chg_flag  <= next_chg_flag;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write channel: address and data taken in either order
   assign s_axi_awready = !aw_held;
   assign s_axi_wready  = !w_held;
   assign s_axi_bvalid  = bvalid;
   assign s_axi_bresp   = bresp;
   assign do_write      = aw_held && w_held && !bvalid;

   always_comb
   begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held  = w_held;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = bvalid;
      next_bresp   = bresp;
      if (s_axi_awvalid && !aw_held)
      begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held)
      begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (do_write)
      begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         case (aw_addr[ADDR_W-1:2])
            OFF_PORT_CTRL[ADDR_W-1:2],
            OFF_SD_CTRL[ADDR_W-1:2],
            OFF_SD_STATUS[ADDR_W-1:2],
            OFF_IRQ_STAT[ADDR_W-1:2],
            OFF_IRQ_MASK[ADDR_W-1:2]: next_bresp = RESP_OKAY;
            default:                  next_bresp = RESP_SLVERR;
         endcase
      end
      if (bvalid && s_axi_bready)
      begin
         next_bvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         aw_addr <= '0;
         w_held  <= 1'b0;
         w_data  <= '0;
         w_strb  <= '0;
         bvalid  <= 1'b0;
         bresp   <= RESP_OKAY;
      end
      else
      begin
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held  <= next_w_held;
         w_data  <= next_w_data;
         w_strb  <= next_w_strb;
         bvalid  <= next_bvalid;
         bresp   <= next_bresp;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read channel: one read at a time, data registered
   assign s_axi_arready = !rvalid;
   assign s_axi_rvalid  = rvalid;
   assign s_axi_rdata   = rdata;
   assign s_axi_rresp   = rresp;
   assign do_read       = s_axi_arvalid && !rvalid;

   always_comb
   begin
      next_rvalid = rvalid;
      next_rdata  = rdata;
      next_rresp  = rresp;
      if (do_read)
      begin
         next_rvalid = 1'b1;
         next_rresp  = RESP_OKAY;
         next_rdata  = '0;
         case (s_axi_araddr[ADDR_W-1:2])
            OFF_PORT_CTRL[ADDR_W-1:2]: next_rdata[REG_W-1:0] = port_ctrl;
            OFF_SD_CTRL[ADDR_W-1:2]:   next_rdata[REG_W-1:0] = sd_ctrl;
            OFF_SD_STATUS[ADDR_W-1:2]: next_rdata[REG_W-1:0] = status_word;
            OFF_IRQ_STAT[ADDR_W-1:2]:  next_rdata[IRQ_W-1:0] = irq_stat;
            OFF_IRQ_MASK[ADDR_W-1:2]:  next_rdata[IRQ_W-1:0] = irq_mask;
            default:                   next_rresp = RESP_SLVERR;
         endcase
      end
      else if (rvalid && s_axi_rready)
      begin
         next_rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid <= 1'b0;
         rdata  <= '0;
         rresp  <= RESP_OKAY;
      end
      else
      begin
         rvalid <= next_rvalid;
         rdata  <= next_rdata;
         rresp  <= next_rresp;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control, interrupt status and mask registers
   assign wmask   = {{8{w_strb[1]}}, {8{w_strb[0]}}};
   assign wval    = w_data[REG_W-1:0];
   assign irq_evt = {pol_chg, filt_chg};

   always_comb
   begin
      next_sd_ctrl   = sd_ctrl;
      next_port_ctrl = port_ctrl;
      next_irq_mask  = irq_mask;
      next_irq_stat  = irq_stat;
      if (do_write)
      begin
         case (aw_addr[ADDR_W-1:2])
            OFF_SD_CTRL[ADDR_W-1:2]:
               next_sd_ctrl = (sd_ctrl & ~(wmask & WMASK_SD_CTRL))
                              | (wval & wmask & WMASK_SD_CTRL);
            OFF_PORT_CTRL[ADDR_W-1:2]:
               next_port_ctrl = (port_ctrl & ~(wmask & WMASK_PORT_CTRL))
                                | (wval & wmask & WMASK_PORT_CTRL);
            OFF_IRQ_MASK[ADDR_W-1:2]:
               if (w_strb[0])
               begin
                  next_irq_mask = wval[IRQ_W-1:0];
               end
            OFF_IRQ_STAT[ADDR_W-1:2]:
               if (w_strb[0])
               begin
                  next_irq_stat = irq_stat & ~wval[IRQ_W-1:0];
               end
            default:
               next_irq_stat = irq_stat;
         endcase
      end
      // New events win over a same-cycle clear
      next_irq_stat = next_irq_stat | irq_evt;
      next_irq      = |(next_irq_stat & next_irq_mask);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sd_ctrl   <= RST_SD_CTRL;
         port_ctrl <= RST_PORT_CTRL;
         irq_mask  <= RST_IRQ;
         irq_stat  <= RST_IRQ;
         irq       <= 1'b0;
      end
      else
      begin
         sd_ctrl   <= next_sd_ctrl;
         port_ctrl <= next_port_ctrl;
         irq_mask  <= next_irq_mask;
         irq_stat  <= next_irq_stat;
         irq       <= next_irq;
      end
   end

endmodule : sds_top

`default_nettype wire

// ===== tb/sds_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module sds_monitor
   import sds_pkg::*;
(
   input wire logic              aclk,
   input wire logic              aresetn,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic [1:0]        s_axi_bresp,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0]        s_axi_rresp,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready,
   input wire logic              sd_pcs_qual
);
   logic [ADDR_W-1:0] rd_a;
   logic              chg_seen;
   logic              rd_chg;
   logic              q_d;
   wire logic         take = s_axi_arvalid && s_axi_arready;
   wire logic         rd_st = rd_a[7:2] == OFF_SD_STATUS[7:2];
   wire logic         rd_map = rd_st || rd_a[7:2] == OFF_SD_CTRL[7:2] ||
                      rd_a[7:2] == OFF_PORT_CTRL[7:2] ||
                      rd_a[7:2] == OFF_IRQ_STAT[7:2] ||
                      rd_a[7:2] == OFF_IRQ_MASK[7:2];

   // Track read address and changes of the filtered detect since last status read
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         rd_a     <= '0;
         chg_seen <= 1'h0;
         rd_chg   <= 1'h0;
         q_d      <= 1'h0;
      end
      else
      begin
         q_d <= sd_pcs_qual;
         if (take)
            rd_a <= s_axi_araddr;
         if (take && s_axi_araddr[7:2] == OFF_SD_STATUS[7:2])
            rd_chg <= chg_seen;
         chg_seen <= (q_d != sd_pcs_qual) ||
                     (chg_seen && !(take &&
                      s_axi_araddr[7:2] == OFF_SD_STATUS[7:2]));
      end

   ////////////////////////////////////////////////////////////////////////
   rd_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
      && $stable(s_axi_rresp)) else $error("read answer dropped");
   wr_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   ar_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
      take |=> s_axi_rvalid && !s_axi_arready) else $error("read late");
   wr_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
      !s_axi_bvalid |-> ##[1:2] s_axi_bvalid) else $error("write late");
   rsv_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && rd_st |-> s_axi_rdata[31:10] == '0 &&
      s_axi_rdata[3:0] == '0) else $error("reserved status bits set");
   resp_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid |-> s_axi_rresp == (rd_map ? RESP_OKAY : RESP_SLVERR))
      else $error("read response wrong");
   unmapped_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && !rd_map |-> s_axi_rdata == '0)
      else $error("unmapped read data");
   filt_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(s_axi_rvalid) && rd_st |-> s_axi_rdata[9] == $past(sd_pcs_qual))
      else $error("status filtered bit differs");
   chg_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(s_axi_rvalid) && rd_st |-> s_axi_rdata[7] == rd_chg)
      else $error("change flag wrong");
endmodule : sds_monitor

`default_nettype wire

// ===== tb/sds_sd_source.sv
`timescale 1ns/1ps
`default_nettype none

module sds_sd_source
(
   input  wire logic aclk,
   input  wire logic lvl,
   input  wire logic glitch,
   output var  logic pin
);
   // Pin follows the level, a glitch cycle inverts it
   initial pin = 1'h0;
   always @(posedge aclk)
      pin <= glitch ? !lvl : lvl;
endmodule : sds_sd_source

`default_nettype wire

// ===== tb/sds_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module sds_top_tb;
   import sds_pkg::*;
   localparam int FC = 2;
   localparam int SETTLE = FC + 10;
   localparam logic [7:0] OFFS [5] = '{OFF_PORT_CTRL, OFF_SD_CTRL,
                                       OFF_SD_STATUS, OFF_IRQ_STAT,
                                       OFF_IRQ_MASK};
   localparam logic [15:0] RSTV [5] = '{RST_PORT_CTRL, RST_SD_CTRL, 16'h0,
                                        {14'h0, RST_IRQ}, {14'h0, RST_IRQ}};
   logic              aclk = 1'h0, aresetn = 1'h0, lvl = 1'h0, glt = 1'h0;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata, d;
   logic [3:0]        s_axi_wstrb = '0, ws = 4'hF;
   logic [1:0]        s_axi_bresp, s_axi_rresp, r;
   logic              s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic              s_axi_arvalid = 1'h0, s_axi_bready = 1'h0;
   logic              s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
   logic              s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic              signal_detect_pin, sd_pcs_qual, irq;
   int                failures = 0, total_checks = 0;

   always #10 aclk = !aclk;

   sds_top #(.FILTER_CYC(FC)) i_sds_top (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .signal_detect_pin, .sd_pcs_qual, .irq);
   sds_sd_source i_sds_sd_source (.aclk, .lvl, .glitch(glt),
      .pin(signal_detect_pin));

   ////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // Bus write: address and data together, bready after a random delay
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int n;
      int w;
      w = $urandom % 5;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= ws;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= (w == 0);
      for (n = 0; n < 99; n++)
      begin
         @(posedge aclk);
         if (n + 1 == w)
            s_axi_bready <= 1'h1;
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid === 1'h1 && s_axi_bready)
            break;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
      if (n == 99)
      begin
         failures++;
         close_out();
      end
   endtask : wr

   // Bus read into d and r, rready after a random delay
   task automatic rd(input logic [7:0] a);
      int n;
      int w;
      w = $urandom % 3;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= (w == 0);
      for (n = 0; n < 99; n++)
      begin
         @(posedge aclk);
         if (n + 1 == w)
            s_axi_rready <= 1'h1;
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid === 1'h1 && s_axi_rready)
            break;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
      if (n == 99)
      begin
         failures++;
         close_out();
      end
   endtask : rd

   function automatic logic [31:0] exp_st(input logic f, p, c);
      return {22'h0, f, p, c, 7'h0};
   endfunction : exp_st

   task automatic st(input logic f, p, c);
      rd(OFF_SD_STATUS);
      chk("status", d, exp_st(f, p, c));
   endtask : st

   // Pin inverted for n cycles, then settle
   task automatic pulse(input int n);
      glt <= 1'h1;
      repeat (n) @(posedge aclk);
      glt <= 1'h0;
      repeat (SETTLE) @(posedge aclk);
   endtask : pulse

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [15:0] c;
      logic        f, p;
      d = $urandom(32'h1271);
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      for (int i = 0; i < 5; i++)
      begin
         rd(OFFS[i]);
         chk("reset value", d, 32'(RSTV[i]));
      end
      rd(8'h10);
      chk("unmapped read", {d[31:2], r}, {30'h0, RESP_SLVERR});
      wr(8'h10, 32'h0000FFFF);
      chk("unmapped write", 32'(r), 32'(RESP_SLVERR));
      // Pin rises through the main filter
      lvl <= 1'h1;
      repeat (SETTLE) @(posedge aclk);
      chk("qual", 32'(sd_pcs_qual), 32'h1);
      st(1'h1, 1'h1, 1'h1);
      st(1'h1, 1'h1, 1'h0);
      // Events latched while masked, then raise and clear
      chk("irq masked", 32'(irq), 32'h0);
      rd(OFF_IRQ_STAT);
      chk("irq status", d, 32'h3);
      wr(OFF_IRQ_MASK, 32'h3);
      repeat (2) @(posedge aclk);
      chk("irq raised", 32'(irq), 32'h1);
      wr(OFF_IRQ_STAT, 32'h3);
      repeat (2) @(posedge aclk);
      chk("irq cleared", 32'(irq), 32'h0);
      wr(OFF_SD_STATUS, 32'h00000380);
      chk("status write", 32'(r), 32'(RESP_OKAY));
      st(1'h1, 1'h1, 1'h0);
      // Short pulses: filter on, then filter disabled
      pulse(FC);
      st(1'h1, 1'h1, 1'h0);
      wr(OFF_SD_CTRL, 32'h00004004);
      pulse(1);
      st(1'h1, 1'h1, 1'h0);
      pulse(2);
      st(1'h1, 1'h1, 1'h1);
      // Power down keeps the polarity view live
      wr(OFF_PORT_CTRL, 32'h00000800);
      lvl <= 1'h0;
      repeat (SETTLE) @(posedge aclk);
      st(1'h1, 1'h0, 1'h0);
      wr(OFF_PORT_CTRL, 32'h0);
      repeat (SETTLE) @(posedge aclk);
      st(1'h0, 1'h0, 1'h1);
      // Detect disabled: output forced high whatever the pin does
      wr(OFF_SD_CTRL, 32'h0);
      repeat (2) @(posedge aclk);
      for (int i = 0; i < 12; i++)
      begin
         lvl <= 1'($urandom);
         @(posedge aclk);
         chk("forced qual", 32'(sd_pcs_qual), 32'h1);
      end
      // Only the upper byte lane lands when its strobe alone is set
      ws = 4'h2;
      wr(OFF_SD_CTRL, 32'h0000400C);
      ws = 4'hF;
      rd(OFF_SD_CTRL);
      chk("lane write", d, 32'h00004000);
      // Random control settings and pin levels
      for (int k = 0; k < 16; k++)
      begin
         c = 16'($urandom) & WMASK_SD_CTRL;
         wr(OFF_SD_CTRL, 32'(c));
         lvl <= 1'($urandom);
         repeat (SETTLE) @(posedge aclk);
         p = lvl ^ c[BIT_SD_INV];
         f = c[BIT_SD_EN] ? p : 1'h1;
         rd(OFF_SD_STATUS);
         st(f, p, 1'h0);
         chk("qual", 32'(sd_pcs_qual), 32'(f));
      end
      close_out();
   end
endmodule : sds_top_tb

bind sds_top sds_monitor i_sds_monitor (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready, .sd_pcs_qual);

`default_nettype wire
